/* File: rtl/msp_pkg.sv */
package msp_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
   localparam logic [31:0] OFS_NVCFG  = 32'h0000_0004;
   localparam logic [31:0] OFS_VCFG   = 32'h0000_0008;
   localparam logic [31:0] OFS_EVCFG  = 32'h0000_000C;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0010;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_REBOOT_BIT = 0;
   localparam int CTRL_RESCUE_BIT = 1;
   localparam int NV_DUAL_N_BIT   = 2;
   localparam int NV_QUAD_N_BIT   = 3;
   localparam int EV_DUAL_N_BIT   = 6;
   localparam int EV_QUAD_N_BIT   = 7;
   localparam int STAT_MODE_LSB   = 0;
   localparam int STAT_VPP_BIT    = 2;
   localparam int STAT_SEL_BIT    = 3;
   localparam int STAT_OVR_BIT    = 4;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] NVCFG_RST = 16'hFFFF;
   localparam logic [7:0]  VCFG_RST  = 8'hFF;
   localparam logic [7:0]  EVCFG_RST = 8'hFF;

   // ****************************************************************
   // Serial commands, bit counts and bus word size
   // ****************************************************************
   localparam logic [7:0] OP_WR_VCFG  = 8'h81;
   localparam logic [7:0] OP_WR_EVCFG = 8'h61;
   localparam logic [7:0] OP_RD_VCFG  = 8'h85;
   localparam logic [7:0] OP_RD_EVCFG = 8'h65;
   localparam logic [4:0] OPC_END     = 5'h08;
   localparam logic [4:0] DATA_END    = 5'h10;
   localparam logic [2:0] HSIZE_WORD  = 3'h2;

   typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} msp_proto_t;
   typedef enum logic [1:0] {ST_OPCODE, ST_WDATA, ST_READ, ST_IGNORE}
      msp_link_st_t;

endpackage

/* File: rtl/msp_serial_front.sv */
`timescale 1ns/1ps
// Summary of operation
// - Inputs sampled on rising serial clock; outputs change on falling edge.
// - Clock idle level low or high makes no difference in any protocol.
// - Output lines driven only while select is asserted, else released.
// - Extended protocol shifts opcode on line zero only.
// - Enhanced volatile write with bit6=0, bit7=1 switches to dual at once.
// - Enhanced volatile write with bit7=0 switches to quad at once.
// - Volatile protocol lost at power-on, reboot, rescue or next enhanced volatile write.
// - Nonvolatile bit2 low, bit3 high starts dual protocol at each reboot.
// - Nonvolatile bit3 low starts quad protocol at each reboot.
// - Quad with supply high during program/erase falls back to extended.
// - Boot loads working configuration from nonvolatile configuration.
// - Each finished enhanced volatile write copies settings into working config.
// - Working configuration has no serial read or write opcode of its own.
// - Nonvolatile protocol enables are active low; ones mean extended.
module msp_serial_front
(
   // System clock and reset
   input  wire logic        I_CLOCK,
   input  wire logic        I_RSTN,
   // AHB-Lite slave
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   output logic [31:0]      O_HRDATA,
   // Serial link
   input  wire logic        I_SCLK,
   input  wire logic        I_SELECT_N,
   input  wire logic [3:0]  I_SERIAL_LINE,
   output logic [3:0]       O_SERIAL_LINE,
   output logic [3:0]       O_SERIAL_LINE_OE,
   // Program/erase supply and core state
   input  wire logic        I_VPP_HIGH,
   input  wire logic        I_PE_BUSY
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   msp_pkg::msp_proto_t   proto_q;
   msp_pkg::msp_link_st_t st_q;
   logic        link_rst_n;
   logic [4:0]  lanes;
   logic [4:0]  cnt_q;
   logic [4:0]  cnt_d;
   logic [7:0]  sh_q;
   logic [7:0]  sh_d;
   logic        rd_q;
   logic [7:0]  rd_val_q;
   logic        wr_is_ev_q;
   logic        wr_tgl_q;
   logic        wr_ev_q;
   logic [7:0]  wr_data_q;
   logic        tx_go_q;
   logic [7:0]  tx_sh_q;
   logic        sel_meta_q;
   logic        sel_sync_q;
   logic        vpp_meta_q;
   logic        vpp_sync_q;
   logic        tgl_meta_q;
   logic        tgl_sync_q;
   logic        tgl_seen_q;
   logic        pend_q;
   logic        pend_ev_q;
   logic [7:0]  pend_data_q;
   logic        commit;
   logic        new_wr;
   logic [15:0] nvcfg_q;
   logic [7:0]  vcfg_q;
   logic [7:0]  evcfg_q;
   logic        work_quad_n_q;
   logic        work_dual_n_q;
   logic        boot_q;
   logic        ovr;
   logic        ahb_take;
   logic        bus_wr_q;
   logic [31:0] bus_addr_q;
   logic        reboot;
   logic        rescue;
   logic [31:0] rd_mux;

   // ****************************************************************
   // Serial link, receive side (rising edge)
   // ****************************************************************
   // Deselect holds the link logic in reset, so stray edges do nothing
   assign link_rst_n = I_RSTN & ~I_SELECT_N;

   // Protocol only changes while deselected, so it is stable all frame
   always_comb
   begin
      case (proto_q)
         msp_pkg::PROTO_DUAL: lanes = 5'h02;
         msp_pkg::PROTO_QUAD: lanes = 5'h04;
         default:             lanes = 5'h01;
      endcase
   end

   always_comb
   begin
      case (proto_q)
         msp_pkg::PROTO_DUAL: sh_d = {sh_q[5:0], I_SERIAL_LINE[1:0]};
         msp_pkg::PROTO_QUAD: sh_d = {sh_q[3:0], I_SERIAL_LINE[3:0]};
         default:             sh_d = {sh_q[6:0], I_SERIAL_LINE[0]};
      endcase
   end

   assign cnt_d = (cnt_q >= msp_pkg::DATA_END) ? cnt_q : cnt_q + lanes;
   // Only rising edges sample, whatever the idle level of the clock
   always_ff @(posedge I_SCLK or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         cnt_q      <= 5'h00;
         sh_q       <= 8'h00;
         st_q       <= msp_pkg::ST_OPCODE;
         rd_q       <= 1'b0;
         rd_val_q   <= 8'h00;
         wr_is_ev_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
         case (st_q)
            msp_pkg::ST_OPCODE:
            begin
               if (cnt_d == msp_pkg::OPC_END)
               begin
                  case (sh_d)
                     msp_pkg::OP_WR_VCFG:
                     begin
                        st_q       <= msp_pkg::ST_WDATA;
                        wr_is_ev_q <= 1'b0;
                     end
                     msp_pkg::OP_WR_EVCFG:
                     begin
                        st_q       <= msp_pkg::ST_WDATA;
                        wr_is_ev_q <= 1'b1;
                     end
                     msp_pkg::OP_RD_VCFG:
                     begin
                        st_q     <= msp_pkg::ST_READ;
                        rd_q     <= 1'b1;
                        rd_val_q <= vcfg_q;
                     end
                     msp_pkg::OP_RD_EVCFG:
                     begin
                        st_q     <= msp_pkg::ST_READ;
                        rd_q     <= 1'b1;
                        rd_val_q <= evcfg_q;
                     end
                     // No opcode reaches the working configuration
                     default: st_q <= msp_pkg::ST_IGNORE;
                  endcase
               end
            end
            msp_pkg::ST_WDATA:
               if (cnt_d == msp_pkg::DATA_END)
                  st_q <= msp_pkg::ST_IGNORE;
            msp_pkg::ST_READ, msp_pkg::ST_IGNORE: st_q <= st_q;
            default:            st_q <= msp_pkg::ST_OPCODE;
         endcase
      end
   end

   // Written byte must outlive the frame, so only power-on resets it
   always_ff @(posedge I_SCLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         wr_tgl_q  <= 1'b0;
         wr_ev_q   <= 1'b0;
         wr_data_q <= 8'h00;
      end
      else if (st_q == msp_pkg::ST_WDATA && cnt_d == msp_pkg::DATA_END)
      begin
         wr_tgl_q  <= ~wr_tgl_q;
         wr_ev_q   <= wr_is_ev_q;
         wr_data_q <= sh_d;
      end
   end

   // ****************************************************************
   // Serial link, transmit side (falling edge)
   // ****************************************************************
   always_ff @(negedge I_SCLK or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         tx_go_q <= 1'b0;
         tx_sh_q <= 8'h00;
      end
      else if (rd_q && !tx_go_q)
      begin
         tx_go_q <= 1'b1;
         tx_sh_q <= rd_val_q;
      end
      else if (tx_go_q)
      begin
         // Rotate so a long read repeats the byte
         case (proto_q)
            msp_pkg::PROTO_DUAL: tx_sh_q <= {tx_sh_q[5:0], tx_sh_q[7:6]};
            msp_pkg::PROTO_QUAD: tx_sh_q <= {tx_sh_q[3:0], tx_sh_q[7:4]};
            default:             tx_sh_q <= {tx_sh_q[6:0], tx_sh_q[7]};
         endcase
      end
   end

   always_comb
   begin
      case (proto_q)
         msp_pkg::PROTO_DUAL:
         begin
            O_SERIAL_LINE    = {2'h0, tx_sh_q[7:6]};
            O_SERIAL_LINE_OE = 4'h3;
         end
         msp_pkg::PROTO_QUAD:
         begin
            O_SERIAL_LINE    = tx_sh_q[7:4];
            O_SERIAL_LINE_OE = 4'hF;
         end
         default:
         begin
            O_SERIAL_LINE    = {2'h0, tx_sh_q[7], 1'h0};
            O_SERIAL_LINE_OE = 4'h2;
         end
      endcase
      // Shared bus: release the lines unless this part is selected and sending read data
      if (!tx_go_q || I_SELECT_N)
         O_SERIAL_LINE_OE = 4'h0;
   end

   // ****************************************************************
   // Crossings into the system clock
   // ****************************************************************
   always_ff @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         sel_meta_q <= 1'b1;
         sel_sync_q <= 1'b1;
         vpp_meta_q <= 1'b0;
         vpp_sync_q <= 1'b0;
         tgl_meta_q <= 1'b0;
         tgl_sync_q <= 1'b0;
         tgl_seen_q <= 1'b0;
      end
      else
      begin
         sel_meta_q <= I_SELECT_N;
         sel_sync_q <= sel_meta_q;
         vpp_meta_q <= I_VPP_HIGH;
         vpp_sync_q <= vpp_meta_q;
         tgl_meta_q <= wr_tgl_q;
         tgl_sync_q <= tgl_meta_q;
         tgl_seen_q <= tgl_sync_q;
      end
   end

   assign new_wr = tgl_sync_q ^ tgl_seen_q;
   // Applied only after deselect, so the frame ends cleanly first
   assign commit = pend_q & sel_sync_q;

   always_ff @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         pend_q      <= 1'b0;
         pend_ev_q   <= 1'b0;
         pend_data_q <= 8'h00;
      end
      else if (new_wr)
      begin
         pend_q      <= 1'b1;
         pend_ev_q   <= wr_ev_q;
         pend_data_q <= wr_data_q;
      end
      else if (commit)
         pend_q <= 1'b0;
   end

   // ****************************************************************
   // Configuration registers and working configuration
   // ****************************************************************
   always_ff @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         vcfg_q        <= msp_pkg::VCFG_RST;
         evcfg_q       <= msp_pkg::EVCFG_RST;
         work_quad_n_q <= 1'b1;
         work_dual_n_q <= 1'b1;
         boot_q        <= 1'b1;
      end
      else if (boot_q || reboot)
      begin
         boot_q        <= 1'b0;
         vcfg_q        <= msp_pkg::VCFG_RST;
         evcfg_q       <= msp_pkg::EVCFG_RST;
         work_quad_n_q <= nvcfg_q[msp_pkg::NV_QUAD_N_BIT];
         work_dual_n_q <= nvcfg_q[msp_pkg::NV_DUAL_N_BIT];
      end
      else if (rescue)
      begin
         evcfg_q[msp_pkg::EV_QUAD_N_BIT] <= 1'b1;
         evcfg_q[msp_pkg::EV_DUAL_N_BIT] <= 1'b1;
         work_quad_n_q <= 1'b1;
         work_dual_n_q <= 1'b1;
      end
      else if (commit && pend_ev_q)
      begin
         evcfg_q       <= pend_data_q;
         work_quad_n_q <= pend_data_q[msp_pkg::EV_QUAD_N_BIT];
         work_dual_n_q <= pend_data_q[msp_pkg::EV_DUAL_N_BIT];
      end
      else if (commit)
         vcfg_q <= pend_data_q;
   end

   // Nonvolatile image: survives reboot, only power-on restores it
   always_ff @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         nvcfg_q <= msp_pkg::NVCFG_RST;
      else if (bus_wr_q && bus_addr_q == msp_pkg::OFS_NVCFG)
         nvcfg_q <= I_HWDATA[15:0];
   end

   assign ovr = vpp_sync_q & I_PE_BUSY;
   // Held inside a frame: the link reads it with no synchroniser
   always_ff @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         proto_q <= msp_pkg::PROTO_EXT;
      else if (!sel_sync_q)
         proto_q <= proto_q;
      else if (!work_quad_n_q)
         proto_q <= ovr ? msp_pkg::PROTO_EXT : msp_pkg::PROTO_QUAD;
      else if (!work_dual_n_q)
         proto_q <= msp_pkg::PROTO_DUAL;
      else
         proto_q <= msp_pkg::PROTO_EXT;
   end

   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   assign ahb_take    = I_HSEL & I_HREADY & I_HTRANS[1];
   assign reboot      = bus_wr_q && bus_addr_q == msp_pkg::OFS_CTRL &&
                        I_HWDATA[msp_pkg::CTRL_REBOOT_BIT];
   assign rescue      = bus_wr_q && bus_addr_q == msp_pkg::OFS_CTRL &&
                        I_HWDATA[msp_pkg::CTRL_RESCUE_BIT];
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP     = 1'b0;

   always_comb
   begin
      case (I_HADDR)
         msp_pkg::OFS_NVCFG: rd_mux = {16'h0000, nvcfg_q};
         msp_pkg::OFS_VCFG:  rd_mux = {24'h000000, vcfg_q};
         msp_pkg::OFS_EVCFG: rd_mux = {24'h000000, evcfg_q};
         msp_pkg::OFS_STATUS:
         begin
            rd_mux = 32'h0000_0000;
            rd_mux[msp_pkg::STAT_MODE_LSB +: 2] = proto_q;
            rd_mux[msp_pkg::STAT_VPP_BIT]       = vpp_sync_q;
            rd_mux[msp_pkg::STAT_SEL_BIT]       = sel_sync_q;
            rd_mux[msp_pkg::STAT_OVR_BIT]       = ovr & ~work_quad_n_q;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         bus_wr_q   <= 1'b0;
         bus_addr_q <= 32'h0000_0000;
         O_HRDATA   <= 32'h0000_0000;
      end
      else
      begin
         bus_wr_q <= ahb_take & I_HWRITE & (I_HSIZE == msp_pkg::HSIZE_WORD);
         if (ahb_take)
            bus_addr_q <= I_HADDR;
         if (ahb_take && !I_HWRITE)
            O_HRDATA <= rd_mux;
      end
   end
endmodule // msp_serial_front

/* File: testbench/msp_serial_front_props.sv */
`timescale 1ns/1ps
module msp_serial_front_props
(
   // System side
   input wire logic        I_CLOCK,
   input wire logic        I_RSTN,
   input wire logic        I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0]  I_HTRANS,
   input wire logic        I_HWRITE,
   input wire logic        I_HREADY,
   input wire logic [31:0] O_HRDATA,
   // Serial side
   input wire logic        I_SCLK,
   input wire logic        I_SELECT_N,
   input wire logic [3:0]  O_SERIAL_LINE,
   input wire logic [3:0]  O_SERIAL_LINE_OE
);
   // **********************************************************
   // Serial pins and status reads, watched from the system clock
   // **********************************************************
   property p_oe_desel;
      @(posedge I_CLOCK) disable iff (!I_RSTN)
      I_SELECT_N |-> O_SERIAL_LINE_OE == 4'h0;
   endproperty
   a_oe_desel: assert property (p_oe_desel)
      else $error("line driven while deselected");
   property p_out_fall;
      @(posedge I_CLOCK) disable iff (!I_RSTN)
      !I_SELECT_N && $changed(O_SERIAL_LINE) |-> !I_SCLK;
   endproperty
   a_out_fall: assert property (p_out_fall)
      else $error("output moved outside clock low phase");
   property p_oe_fall;
      @(posedge I_CLOCK) disable iff (!I_RSTN)
      !I_SELECT_N && $changed(O_SERIAL_LINE_OE) |-> !I_SCLK;
   endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("enable moved outside clock low phase");
   property p_oe_legal;
      @(posedge I_CLOCK) disable iff (!I_RSTN)
      O_SERIAL_LINE_OE inside {4'h0, 4'h2, 4'h3, 4'hF};
   endproperty
   a_oe_legal: assert property (p_oe_legal)
      else $error("enable pattern fits no protocol");
   property p_oe_hold;
      @(posedge I_CLOCK) disable iff (!I_RSTN)
      O_SERIAL_LINE_OE != 4'h0 && !I_SELECT_N |=>
      I_SELECT_N || O_SERIAL_LINE_OE != 4'h0;
   endproperty
   a_oe_hold: assert property (p_oe_hold)
      else $error("enable dropped inside frame");
   // Another device may be clocked while this one is idle
   property p_quiet;
      @(posedge I_CLOCK) disable iff (!I_RSTN)
      I_SELECT_N && $past(I_SELECT_N) && $changed(I_SCLK)
      |-> $stable(O_SERIAL_LINE);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("clock edge acted while deselected");
   property p_hold_high;
      @(posedge I_CLOCK) disable iff (!I_RSTN)
      !I_SELECT_N && I_SCLK && $past(I_SCLK) |-> $stable(O_SERIAL_LINE);
   endproperty
   a_hold_high: assert property (p_hold_high)
      else $error("output moved in clock high phase");
   property p_status;
      @(posedge I_CLOCK) disable iff (!I_RSTN)
      I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE &&
      I_HADDR == msp_pkg::OFS_STATUS |=>
      O_HRDATA[31:5] == 27'h0 && (!O_HRDATA[4] || O_HRDATA[2]);
   endproperty
   a_status: assert property (p_status)
      else $error("fallback shown without supply");
   c_quad: cover property (@(posedge I_CLOCK) O_SERIAL_LINE_OE == 4'hF);
   c_dual: cover property (@(posedge I_CLOCK) O_SERIAL_LINE_OE == 4'h3);
   c_ext: cover property (@(posedge I_CLOCK) O_SERIAL_LINE_OE == 4'h2);
endmodule // msp_serial_front_props

bind msp_serial_front msp_serial_front_props i_props
(
   .I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL),
   .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
   .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .I_SCLK(I_SCLK),
   .I_SELECT_N(I_SELECT_N), .O_SERIAL_LINE(O_SERIAL_LINE),
   .O_SERIAL_LINE_OE(O_SERIAL_LINE_OE)
);

/* File: testbench/msp_host_model.sv */
`timescale 1ns/1ps
module msp_host_model
(
   // Serial lines toward the device
   output logic            o_sclk,
   output logic            o_select_n,
   output logic [3:0]      o_line,
   input  wire logic [3:0] i_line
);
   localparam realtime HALF = 62.5;

   initial
   begin
      o_sclk = 1'b0;
      o_select_n = 1'b1;
      o_line = 4'h5;
   end

   // Another device on the shared bus is clocked meanwhile
   task automatic other(input int n);
      // Keep these edges off the system clock edges
      #3;
      for (int k = 0; k < n; k++)
      begin
         #HALF o_sclk = ~o_sclk;
         o_line = ~o_line;
         #HALF o_sclk = ~o_sclk;
      end
   endtask

   task automatic xfer(input logic [7:0] op, input logic [7:0] wd,
      input int w, input int ng, input logic cp, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {op, wd};
      rd = 8'h00;
      #17 o_sclk = cp;
      #HALF o_select_n = 1'b0;
      for (int g = 0; g < 8 / w + ng; g++)
      begin
         #HALF o_sclk = 1'b0;
         // Undriven lines never keep a stale value
         o_line = ~o_line;
         for (int b = 0; b < w; b++)
            o_line[b] = sh[16 - w + b];
         sh = sh << w;
         #HALF o_sclk = 1'b1;
         for (int b = w - 1; b >= 0; b--)
            rd = {rd[6:0], w == 1 ? i_line[1] : i_line[b]};
      end
      #HALF o_sclk = cp;
      #HALF o_select_n = 1'b1;
      o_line = ~o_line;
   endtask
endmodule // msp_host_model

/* File: testbench/msp_serial_front_tb_top.sv */
`timescale 1ns/1ps
module msp_serial_front_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        vpp = 1'b0;
   logic        busy = 1'b0;
   logic        hready;
   logic        hresp;
   logic [31:0] hrdata;
   logic        sclk;
   logic        sel_n;
   logic [3:0]  h_line;
   logic [3:0]  d_out;
   logic [3:0]  d_oe;
   wire  [3:0]  line = (d_oe & d_out) | (~d_oe & h_line);
   logic [1:0]  cur = 2'h0;
   int          bad_count = 0;
   int          total_checks = 0;
   int          seed = 32'h50FE;

   always #5 clk = ~clk;

   msp_serial_front i_dut
   (
      .I_CLOCK(clk), .I_RSTN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
      .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready),
      .O_HRESP(hresp), .O_HRDATA(hrdata), .I_SCLK(sclk), .I_SELECT_N(sel_n),
      .I_SERIAL_LINE(line), .O_SERIAL_LINE(d_out),
      .O_SERIAL_LINE_OE(d_oe), .I_VPP_HIGH(vpp), .I_PE_BUSY(busy)
   );
   msp_host_model i_host
   (
      .o_sclk(sclk), .o_select_n(sel_n), .o_line(h_line), .i_line(line)
   );

   // **********************************************************
   // Expectations and bus tasks
   // **********************************************************
   function automatic logic [1:0] md(input logic q_n, input logic d_n);
      return !q_n ? 2'h2 : !d_n ? 2'h1 : 2'h0;
   endfunction
   function automatic int wid(input logic [1:0] m);
      return m == 2'h2 ? 4 : m == 2'h1 ? 2 : 1;
   endfunction

   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e,
      input string n);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(n, e, r);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // A frame in the current protocol, cut short by cut groups
   task automatic ser(input logic [7:0] op, input logic [7:0] wd,
      input int cut, output logic [7:0] rd);
      i_host.xfer(op, wd, wid(cur), 8 / wid(cur) - cut,
         1'($random(seed)), rd);
      repeat (8) @(posedge clk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #800us;
      bad_count++;
      report_and_stop;
   end

   // **********************************************************
   // Main sequence
   // **********************************************************
   initial
   begin
      logic [31:0] r;
      logic [7:0]  v;
      logic [7:0]  b;
      logic [15:0] nv [4];
      nv = '{16'hFFF3, 16'hFFFB, 16'hFFF7, 16'hFFFF};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(msp_pkg::OFS_NVCFG, 32'hFFFF, "nvcfg");
      rchk(msp_pkg::OFS_VCFG, 32'hFF, "vcfg");
      rchk(msp_pkg::OFS_EVCFG, 32'hFF, "evcfg");
      rchk(msp_pkg::OFS_STATUS, 32'h8, "status");
      rchk(32'h40, 32'h0, "unmapped");
      // Non-word write must leave the nonvolatile image alone
      hsize <= 3'h0;
      wr(msp_pkg::OFS_NVCFG, 32'h0);
      hsize <= msp_pkg::HSIZE_WORD;
      rchk(msp_pkg::OFS_NVCFG, 32'hFFFF, "byte write");
      for (int i = 0; i < 12; i++)
      begin
         v = i == 0 ? 8'h7F : i == 1 ? 8'hBF : 8'($random(seed));
         i_host.other(3);
         ser(msp_pkg::OP_WR_EVCFG, v, 0, b);
         cur = md(v[7], v[6]);
         rchk(msp_pkg::OFS_EVCFG, {24'h0, v}, "evcfg");
         rchk(msp_pkg::OFS_STATUS, {28'h0, 2'h2, cur}, "mode");
         ser(msp_pkg::OP_RD_EVCFG, ~v, 0, b);
         chk("serial read", {24'h0, v}, {24'h0, b});
      end
      // Partial byte and unknown opcode leave the setting alone
      ser(msp_pkg::OP_WR_EVCFG, ~v, 1, b);
      ser(8'h00, ~v, 0, b);
      rchk(msp_pkg::OFS_EVCFG, {24'h0, v}, "partial");
      ser(msp_pkg::OP_WR_VCFG, 8'h5A, 0, b);
      ser(msp_pkg::OP_RD_VCFG, 8'h00, 0, b);
      chk("vcfg read", 32'h5A, {24'h0, b});
      wr(msp_pkg::OFS_CTRL, 32'h2);
      cur = 2'h0;
      rchk(msp_pkg::OFS_EVCFG, {24'h0, 2'h3, v[5:0]}, "rescue");
      rchk(msp_pkg::OFS_STATUS, 32'h8, "rescue mode");
      for (int j = 0; j < 4; j++)
      begin
         wr(msp_pkg::OFS_NVCFG, {16'h0, nv[j]});
         wr(msp_pkg::OFS_CTRL, 32'h1);
         cur = md(nv[j][3], nv[j][2]);
         rchk(msp_pkg::OFS_STATUS, {28'h0, 2'h2, cur}, "nv");
         ser(msp_pkg::OP_RD_EVCFG, 8'h00, 0, b);
         chk("boot evcfg", 32'hFF, {24'h0, b});
      end
      ser(msp_pkg::OP_WR_EVCFG, 8'h7F, 0, b);
      busy <= 1'b1;
      vpp <= 1'b1;
      repeat (4) @(posedge clk);
      bus(1'b0, msp_pkg::OFS_STATUS, 32'h0, r);
      chk("fallback", 32'h14, r & 32'h14);
      ser(msp_pkg::OP_RD_EVCFG, 8'h00, 0, b);
      chk("fallback read", 32'h7F, {24'h0, b});
      vpp <= 1'b0;
      cur = 2'h2;
      repeat (4) @(posedge clk);
      ser(msp_pkg::OP_RD_EVCFG, 8'h00, 0, b);
      chk("quad again", 32'h7F, {24'h0, b});
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      busy <= 1'b0;
      repeat (4) @(posedge clk);
      cur = 2'h0;
      rchk(msp_pkg::OFS_STATUS, 32'h8, "power on");
      ser(msp_pkg::OP_RD_EVCFG, 8'h00, 0, b);
      chk("power on evcfg", 32'hFF, {24'h0, b});
      report_and_stop;
   end
endmodule // msp_serial_front_tb_top
